// File: rtl/mode_cfg_pkg.sv
// How it works
// - Bits 15:14 always read back as zero, whatever was written.
// - Bit 13 enables register-map CRC checking; off after reset.
// - Bit 12 enables CRC checking of incoming command frames; off after reset.
// - Bit 11 picks CRC polynomial: 0 CCITT (reset), 1 ANSI.
// - Bit 10 reads one after reset; writing zero clears it and status copy.
// - Bits 9:8 word length: 00 16-bit, 01 24-bit (reset), 10 32 zero-pad.
// - Code 11 gives 32-bit words with sign extension into top byte.
// - Bit 4 enables interface timeout; enabled after reset.
// - Status bit 10 reads one after reset, flagging a reset occurred.
package mode_cfg_pkg;

    localparam logic [7:0] MODE_INDEX = 8'h02;
    localparam logic [7:0] STATUS_INDEX = 8'h01;
    localparam logic [7:0] IRQ_STATUS_INDEX = 8'h10;
    localparam logic [7:0] IRQ_MASK_INDEX = 8'h11;

    localparam logic [15:0] MODE_RESET = 16'h0510;
    localparam logic [15:0] MODE_WRITE_MASK = 16'h3F1F;

    localparam int REG_CRC_BIT = 13;
    localparam int RX_CRC_BIT = 12;
    localparam int CRC_TYPE_BIT = 11;
    localparam int RESET_FLAG_BIT = 10;
    localparam int WLEN_LO = 8;
    localparam int TIMEOUT_BIT = 4;

    localparam logic [1:0] WLEN_16 = 2'h0;
    localparam logic [1:0] WLEN_24 = 2'h1;
    localparam logic [1:0] WLEN_32_PAD = 2'h2;
    localparam logic [1:0] WLEN_32_SIGN = 2'h3;

    // Interrupt events: bit 0 mode register written, bit 1 reset flag cleared
    localparam int IRQ_BITS = 2;
    localparam int IRQ_MODE_WRITE = 0;
    localparam int IRQ_RESET_CLEAR = 1;

    typedef struct packed {
        logic reg_crc_enable;
        logic rx_crc_enable;
        logic crc_polynomial;
        logic [1:0] word_size_select;
        logic timeout_enable;
        logic [1:0] sample_ready_source_select;
        logic sample_ready_idle_state;
        logic sample_ready_pulse_format;
    } mode_fields_t;

endpackage

// File: rtl/word_formatter.sv
`timescale 1ns/1ps
module word_formatter
    import mode_cfg_pkg::*;
(
    input wire logic [1:0] word_size_select,
    input wire logic [23:0] sample,
    output logic [31:0] word,
    output logic [5:0] word_bits
);
    // Result left-justified in 32 bits except code 11, which is sign-extended and right-justified; word_bits gives the valid length
    always_comb begin
        case (word_size_select)
            WLEN_16: begin
                word = {sample[23:8], 16'h0000};
                word_bits = 6'h10;
            end
            WLEN_24: begin
                word = {sample, 8'h00};
                word_bits = 6'h18;
            end
            WLEN_32_PAD: begin
                word = {sample, 8'h00};
                word_bits = 6'h20;
            end
            default: begin
                word = {{8{sample[23]}}, sample};
                word_bits = 6'h20;
            end
        endcase
    end
endmodule

// File: rtl/mode_cfg_regs.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module mode_cfg_regs
    import mode_cfg_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [23:0] sample,
    output mode_fields_t mode_fields,
    output logic reset_occurred,
    output logic [31:0] formatted_word,
    output logic [5:0] formatted_bits,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] mode_reg;
    logic reset_flag;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic wr_pending;
    logic [7:0] wr_index;
    logic [7:0] addr_index;
    logic take;
    logic wr_now;
    logic [15:0] mode_view;
    logic [15:0] status_view;
    logic [IRQ_BITS-1:0] events;
    logic [31:0] next_rdata;
    logic [31:0] word_c;
    logic [5:0] bits_c;
    logic mode_write;
    logic status_clear;
    logic [15:0] next_mode;
    logic next_flag;
    logic [IRQ_BITS-1:0] next_status;
    logic [IRQ_BITS-1:0] next_mask;

    assign addr_index = haddr[9:2];
    assign take = hsel && htrans[1] && hready;
    assign wr_now = wr_pending;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mode_write = wr_now && wr_index == MODE_INDEX;
    assign status_clear = wr_now && wr_index == IRQ_STATUS_INDEX;

    ////////////////////////////////////////////////////////////////////////
    // Write address captured in address phase, data used in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_index <= 8'h00;
        end else begin
            wr_pending <= take && hwrite;
            wr_index <= addr_index;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register; bits 15:14 and 7:5 never stored so they read zero
    // reserved writes dropped
    assign next_mode = mode_write ? (hwdata[15:0] & MODE_WRITE_MASK) : mode_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= MODE_RESET & MODE_WRITE_MASK;
        end else begin
            mode_reg <= next_mode;
        end
    end

    // Reset-occurred flag shared by mode bit 10 and status bit 10
    // cleared by writing zero
    assign next_flag = reset_flag && !(mode_write && !hwdata[RESET_FLAG_BIT]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_flag <= 1'b1;
        end else begin
            reset_flag <= next_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Views use post-edge values so a read pipelined behind a write sees it
    // top bits read zero
    always_comb begin
        mode_view = next_mode & MODE_WRITE_MASK & ~(16'h0001 << RESET_FLAG_BIT);
        mode_view[RESET_FLAG_BIT] = next_flag;
    end

    // Status mirrors mode bits 11 and 9:8 plus the reset flag, other bits read zero
    always_comb begin
        status_view = 16'h0000;
        status_view[RX_CRC_BIT] = 1'b0;
        status_view[CRC_TYPE_BIT] = next_mode[CRC_TYPE_BIT];
        status_view[RESET_FLAG_BIT] = next_flag;
        status_view[WLEN_LO+1 -: 2] = next_mode[WLEN_LO+1 -: 2];
    end

    always_comb begin
        mode_fields.reg_crc_enable = mode_reg[REG_CRC_BIT];
        mode_fields.rx_crc_enable = mode_reg[RX_CRC_BIT];
        mode_fields.crc_polynomial = mode_reg[CRC_TYPE_BIT];
        mode_fields.word_size_select = mode_reg[WLEN_LO+1 -: 2];
        mode_fields.timeout_enable = mode_reg[TIMEOUT_BIT];
        mode_fields.sample_ready_source_select = mode_reg[3:2];
        mode_fields.sample_ready_idle_state = mode_reg[1];
        mode_fields.sample_ready_pulse_format = mode_reg[0];
    end

    assign reset_occurred = reset_flag;

    ////////////////////////////////////////////////////////////////////////
    // sample formatting
    word_formatter word_formatter_i (
        .word_size_select(mode_reg[WLEN_LO+1 -: 2]),
        .sample(sample),
        .word(word_c),
        .word_bits(bits_c)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            formatted_word <= 32'h00000000;
            formatted_bits <= 6'h00;
        end else begin
            formatted_word <= word_c;
            formatted_bits <= bits_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events; set wins over write-one-to-clear
    always_comb begin
        events = '0;
        events[IRQ_MODE_WRITE] = mode_write;
        events[IRQ_RESET_CLEAR] = mode_write && !hwdata[RESET_FLAG_BIT] && reset_flag;
    end

    generate
        for (genvar i = 0; i < IRQ_BITS; i++) begin : g_status
            assign next_status[i] = events[i]
                || (irq_status[i] && !(status_clear && hwdata[i]));
        end
    endgenerate

    assign next_mask = (wr_now && wr_index == IRQ_MASK_INDEX) ? hwdata[IRQ_BITS-1:0]
        : irq_mask;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_status;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= '0;
        end else begin
            irq_mask <= next_mask;
        end
    end

    // From next values so a clear or unmask shows with no extra cycle of lag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data registered at the address phase; unmapped reads zero
    always_comb begin
        next_rdata = 32'h00000000;
        case (addr_index)
            MODE_INDEX: next_rdata = {16'h0000, mode_view};
            STATUS_INDEX: next_rdata = {16'h0000, status_view};
            IRQ_STATUS_INDEX: next_rdata = {{(32-IRQ_BITS){1'b0}}, next_status};
            IRQ_MASK_INDEX: next_rdata = {{(32-IRQ_BITS){1'b0}}, next_mask};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

endmodule

// File: tb/mode_cfg_properties.sv
`timescale 1ns/1ps
module mode_cfg_checker
    import mode_cfg_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic [23:0] sample,
    input wire mode_fields_t mode_fields,
    input wire logic reset_occurred,
    input wire logic [31:0] formatted_word,
    input wire logic [5:0] formatted_bits
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic taken;
    logic wr_d;
    assign taken = hsel && htrans[1] && hready && haddr == 32'h00000008;
    // Marks the data phase of a mode write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_d <= 1'b0;
        end else begin
            wr_d <= taken && hwrite;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    reserved_read_zero_a: assert property (taken && !hwrite |=>
        hrdata[15:14] == 2'h0 && hrdata[7:5] == 3'h0) else $error("reserved bits read set");
    crc_enable_store_a: assert property (wr_d |=>
        mode_fields.reg_crc_enable == $past(hwdata[13])
        && mode_fields.rx_crc_enable == $past(hwdata[12])) else $error("crc enables wrong");
    poly_select_a: assert property (wr_d |=>
        mode_fields.crc_polynomial == $past(hwdata[11])) else $error("polynomial wrong");
    flag_clear_a: assert property (wr_d && !hwdata[10] |=> !reset_occurred)
        else $error("reset flag not cleared");
    flag_no_set_a: assert property (!$rose(reset_occurred))
        else $error("reset flag set by write");
    word_24_a: assert property (mode_fields.word_size_select == WLEN_24 |=>
        formatted_bits == 6'h18 && formatted_word == {$past(sample), 8'h00})
        else $error("24 bit word wrong");
    sign_extend_a: assert property (mode_fields.word_size_select == WLEN_32_SIGN |=>
        formatted_bits == 6'h20 && formatted_word == {{8{$past(sample[23])}}, $past(sample)})
        else $error("sign extended word wrong");
    timeout_store_a: assert property (wr_d |=>
        mode_fields.timeout_enable == $past(hwdata[4])) else $error("timeout enable wrong");
    ready_fields_a: assert property (wr_d |=>
        mode_fields[3:0] == $past(hwdata[3:0])) else $error("sample ready fields wrong");
endmodule
bind mode_cfg_regs mode_cfg_checker mode_cfg_checker_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hrdata, .sample, .mode_fields, .reset_occurred,
    .formatted_word, .formatted_bits);

// File: tb/ahb_host_model.sv
`timescale 1ns/1ps
module ahb_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        // Idle address never repeats the last one
        haddr <= ~a;
        hwdata <= w ? (wd & 32'hFFFFFF1F) : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule

// File: tb/test_adc_mode_config_register.sv
`timescale 1ns/1ps
module test_adc_mode_config_register
    import mode_cfg_pkg::*;
;
    typedef struct packed {
        logic [15:0] wr;
        logic [15:0] rd;
        logic [15:0] st;
        logic [31:0] fw;
        logic [5:0] fb;
    } row_t;
    localparam row_t ROWS [4] = '{
        '{16'hFF1F, 16'h3F1F, 16'h0F00, 32'hFF9ABCDE, 6'h20},
        '{16'h0000, 16'h0000, 16'h0000, 32'h9ABC0000, 6'h10},
        '{16'h0600, 16'h0200, 16'h0200, 32'h9ABCDE00, 6'h20},
        '{16'hD11E, 16'h111E, 16'h0100, 32'h9ABCDE00, 6'h18}};
    logic hclk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic hreadyout;
    logic hresp;
    logic reset_occurred;
    logic irq;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] formatted_word;
    logic [31:0] rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [23:0] sample;
    logic [5:0] formatted_bits;
    mode_fields_t mode_fields;
    int fails = 0;
    int n_compared = 0;
    mode_cfg_regs mode_cfg_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sample(sample),
        .mode_fields(mode_fields), .reset_occurred(reset_occurred),
        .formatted_word(formatted_word), .formatted_bits(formatted_bits), .irq(irq));
    ahb_host_model ahb_host_model_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        ahb_host_model_i.xfer(a, 1'b1, d, rd);
    endtask
    task rdc(input logic [31:0] a, input logic [31:0] exp);
        ahb_host_model_i.xfer(a, 1'b0, 32'h0, rd);
        check(rd, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        fails++;
        conclude;
    end
    initial begin
        hresetn = 1'b0;
        sample = 24'h9ABCDE;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (ROWS[i]) begin
            wr(32'h00000008, {16'h0, ROWS[i].wr});
            rdc(32'h00000008, {16'h0, ROWS[i].rd});
            rdc(32'h00000004, {16'h0, ROWS[i].st});
            check({22'h0, mode_fields}, {22'h0, ROWS[i].rd[13:11], ROWS[i].rd[9:8],
                ROWS[i].rd[4:0]});
            check(formatted_word, ROWS[i].fw);
            check({26'h0, formatted_bits}, {26'h0, ROWS[i].fb});
            check({31'h0, hresp}, 32'h0);
        end
        check({31'h0, reset_occurred}, 32'h0);
        // Unmapped place reads zero and ignores writes
        rdc(32'h00000100, 32'h0);
        wr(32'h00000100, 32'h0000FFFF);
        rdc(32'h00000008, 32'h0000111E);
        rdc(32'h00000040, 32'h00000003);
        check({31'h0, irq}, 32'h0);
        wr(32'h00000044, 32'h00000002);
        @(posedge hclk);
        #1 check({31'h0, irq}, 32'h1);
        wr(32'h00000040, 32'h00000002);
        @(posedge hclk);
        #1 check({31'h0, irq}, 32'h0);
        rdc(32'h00000040, 32'h00000001);
        // Positive sample: sign extension must fill the top byte with zeros
        sample <= 24'h5ABCDE;
        wr(32'h00000008, 32'h0000031E);
        @(posedge hclk);
        #1 check(formatted_word, 32'h005ABCDE);
        // Second reset in mid-run restores defaults
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(32'h00000008, 32'h00000510);
        rdc(32'h00000004, 32'h00000500);
        check({31'h0, reset_occurred}, 32'h1);
        check({31'h0, irq}, 32'h0);
        conclude;
    end
endmodule
